// file: common/frp_pkg.sv
/*
  Constants, code values and the 5B-to-4B table for the fast ethernet receive PCS.
  Assumes a 125 MHz system clock and a serial code stream clocked by a recovered link clock.
*/
package frp_pkg;

  // System clock and hold timer
  localparam int CLK_PERIOD_PS = 8000;
  localparam int HOLD_TIME_US = 722;
  // Longest time, so the division rounds down
  localparam int HOLD_CYCLES = (HOLD_TIME_US * 1000000) / CLK_PERIOD_PS;
  localparam int HOLD_W = 17;
  typedef logic [HOLD_W-1:0] frp_hold_t;

  // Descrambler lock and keep-alive
  localparam int LOCK_BITS = 40;
  localparam int IDLE_RELOAD_BITS = 20;
  localparam int RUN_W = 6;
  localparam int LFSR_W = 11;
  localparam int LFSR_TAP_A = 10;
  localparam int LFSR_TAP_B = 8;

  // Symbol framing
  localparam int SYM_BITS = 5;
  localparam int WIN_BITS = 10;
  localparam logic [9:0] JK_PAIR = 10'h311;
  localparam logic [4:0] SYM_T = 5'h0D;
  localparam logic [4:0] SYM_R = 5'h07;
  localparam logic [3:0] NIB_PREAMBLE = 4'h5;
  localparam logic [3:0] NIB_BAD_SSD = 4'hE;

  // Word passed from the link side: {crs, dv, er, nibble}
  localparam int WORD_W = 7;
  localparam int W_CRS = 6;
  localparam int W_DV = 5;
  localparam int W_ER = 4;
  localparam logic [6:0] WORD_END = 7'h00;

  // MII clock derived from the system clock
  localparam logic [2:0] MII_DIV_LAST = 3'h4;
  localparam logic [2:0] MII_HIGH_END = 3'h2;
  localparam logic [2:0] MII_CHANGE = 3'h2;

  typedef enum logic [1:0] {LS_IDLE, LS_CARRIER, LS_DATA, LS_BAD} frp_lstate_t;

  // Returns {invalid, nibble}; anything that is not a data code is invalid
  function automatic logic [4:0] frp_dec5(input logic [4:0] s);
    logic [4:0] r;
    r = 5'h1E;
    case (s)
      5'h1E: r = 5'h00;
      5'h09: r = 5'h01;
      5'h14: r = 5'h02;
      5'h15: r = 5'h03;
      5'h0A: r = 5'h04;
      5'h0B: r = 5'h05;
      5'h0E: r = 5'h06;
      5'h0F: r = 5'h07;
      5'h12: r = 5'h08;
      5'h13: r = 5'h09;
      5'h16: r = 5'h0A;
      5'h17: r = 5'h0B;
      5'h1A: r = 5'h0C;
      5'h1B: r = 5'h0D;
      5'h1C: r = 5'h0E;
      5'h1D: r = 5'h0F;
      default: r = 5'h1E;
    endcase
    return r;
  endfunction

endpackage

// file: rtl/frp_buf2.sv
/*
  Small flip-flop FIFO with valid/ready on both sides, two entries by default.
  Assumes one clock, a synchronous active-low reset and a clock enable.
*/
module frp_buf2 #(
  parameter int W = 7,
  parameter int DEPTH = 2
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST = (AW)'(DEPTH - 1);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;

  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign in_ready = (count != FULL);
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else if (ce) begin
      if (push) begin
        mem[wr_ptr] <= in_data;
        wr_ptr <= (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// file: rtl/frp_rx_pcs.sv
/*
  Receive PCS for one 100 Mbit/s port: NRZI decode, descrambler lock with hold timer,
  J/K alignment, 5B/4B decode, carrier sense and bad-SSD handling, then an MII-side output.
  Assumes line_bit is sampled on clk_link by the clock recovery, and that sig_det and link_ok
  are asynchronous levels from the analog front end and link monitor.
*/
// Overview of operation
// - Accept a 125 Mbit/s code stream from copper or fiber receivers.
// - Convert the recovered bits from NRZI to NRZ, unaligned, before descrambling.
// - Lock the descrambler after an idle run of 40 bits, loading matching state.
// - Once locked, descramble each bit by XOR with the local LFSR output.
// - On lock, start a 722 us hold countdown.
// - Enough descrambled idle restarts a fresh 722 us countdown, indefinitely.
// - Countdown expiry without idle drops lock and restarts synchronisation.
// - Find the 11000 10001 start pair and frame all later data on it.
// - Start pair after idle is replaced by preamble nibbles on receive data.
// - Decode each 5B symbol to 4B until the T/R end pair.
// - Decoded nibble appears on four-bit rxd, bit 0 the least significant.
// - rxd and rx_dv change synchronously to the receive clock rx_clk.
// - rx_dv rises with the first nibble translated from the start pair.
// - rx_dv falls on end pair, link failure or lost signal, first wins.
// - While rx_dv is high, rx_er flags each invalid code word.
// - Carrier on two non-adjacent zeros in ten bits; off on T/R end pair, or on idle pair after a false carrier.
// - Carrier without start pair gives rx_er and nibble 1110 until two idles.
module frp_rx_pcs #(
  parameter int HOLD_CYCLES = frp_pkg::HOLD_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic clk_link,
  input wire logic line_bit,
  input wire logic sig_det,
  input wire logic link_ok,
  output logic rx_clk,
  output logic [3:0] rxd,
  output logic rx_dv,
  output logic rx_er,
  output logic crs
);

  // ---------------- Link clock domain ----------------
  // Reset, enable and front-end levels all pass two flip-flops into this domain
  logic rst_m;
  logic rst_l_b;
  logic ce_m;
  logic ce_l;
  logic sig_m;
  logic sig_s;
  logic lnk_m;
  logic lnk_s;

  always_ff @(posedge clk_link) begin
    rst_m <= rst_b;
    rst_l_b <= rst_m;
    ce_m <= ce;
    ce_l <= ce_m;
    sig_m <= sig_det;
    sig_s <= sig_m;
    lnk_m <= link_ok;
    lnk_s <= lnk_m;
  end

  logic rx_prev;
  logic [frp_pkg::LFSR_W-1:0] lfsr;
  logic [frp_pkg::RUN_W-1:0] match_cnt;
  logic [frp_pkg::RUN_W-1:0] ones_cnt;
  logic locked;
  frp_pkg::frp_hold_t hold_cnt;
  logic [9:0] sh;

  // One code bit per link clock, i.e. 125 Mbit/s on a real link
  wire nrz = line_bit ^ rx_prev;
  wire key = lfsr[frp_pkg::LFSR_TAP_A] ^ lfsr[frp_pkg::LFSR_TAP_B];
  wire dbit = nrz ^ key;
  // Scrambled idle is the inverted key stream, so a correct prediction means idle
  wire predict_ok = (~nrz) == key;
  wire lock_now = !locked && predict_ok
                  && (match_cnt == frp_pkg::RUN_W'(frp_pkg::LOCK_BITS - 1));
  wire reload = locked && dbit
                && (ones_cnt == frp_pkg::RUN_W'(frp_pkg::IDLE_RELOAD_BITS - 1));
  wire expire = locked && !reload && (hold_cnt == '0);

  always_ff @(posedge clk_link) begin
    if (!rst_l_b) begin
      rx_prev <= 1'b0;
      lfsr <= '0;
      match_cnt <= '0;
      ones_cnt <= '0;
      locked <= 1'b0;
      hold_cnt <= '0;
      sh <= '0;
    end else if (ce_l) begin
      rx_prev <= line_bit;
      // Before lock the LFSR is fed the inverted stream, which is the far-end state in idle
      lfsr <= {lfsr[frp_pkg::LFSR_W-2:0], locked ? key : ~nrz};
      sh <= {sh[8:0], dbit};
      if (!locked) begin
        match_cnt <= predict_ok ? match_cnt + 1'b1 : '0;
        ones_cnt <= '0;
        if (lock_now) begin
          locked <= 1'b1;
          hold_cnt <= frp_pkg::frp_hold_t'(HOLD_CYCLES);
        end
      end else begin
        ones_cnt <= (dbit && !reload) ? ones_cnt + 1'b1 : '0;
        if (reload) begin
          hold_cnt <= frp_pkg::frp_hold_t'(HOLD_CYCLES);
        end else if (expire) begin
          locked <= 1'b0;
          match_cnt <= '0;
        end else begin
          hold_cnt <= hold_cnt - 1'b1;
        end
      end
    end
  end

  // Carrier detect: a zero with another zero two or more places later in the window
  logic [9:0] zeros;
  logic [7:0] pair;
  assign zeros = ~sh;
  generate
    for (genvar i = 0; i < 8; i++) begin : g_pair
      assign pair[i] = zeros[i] && |(zeros[9:i+2]);
    end
  endgenerate

  wire crs_hit = |pair;
  wire idle_pair = &sh;
  wire jk_hit = (sh == frp_pkg::JK_PAIR);
  wire abort = !locked || !sig_s || !lnk_s;
  wire [4:0] sym = sh[4:0];
  wire [4:0] dec = frp_pkg::frp_dec5(sym);
  wire [6:0] sym_word = {2'b11, dec};

  frp_pkg::frp_lstate_t lstate;
  logic [3:0] bitcnt;
  logic idle_before;
  logic prev_t;
  logic [6:0] held;
  logic emit_v;
  logic [6:0] emit_w;

  wire tick = (bitcnt == 4'(frp_pkg::SYM_BITS - 1));
  wire [3:0] bit_next = tick ? 4'h0 : bitcnt + 4'h1;
  wire [6:0] pre_word = {3'b110, frp_pkg::NIB_PREAMBLE};
  wire [6:0] bad_word = {3'b101, frp_pkg::NIB_BAD_SSD};
  wire [6:0] err_word = {3'b111, frp_pkg::NIB_BAD_SSD};

  always_ff @(posedge clk_link) begin
    if (!rst_l_b) begin
      lstate <= frp_pkg::LS_IDLE;
      bitcnt <= '0;
      idle_before <= 1'b0;
      prev_t <= 1'b0;
      held <= '0;
      emit_v <= 1'b0;
      emit_w <= '0;
    end else if (ce_l) begin
      emit_v <= 1'b0;
      case (lstate)
        frp_pkg::LS_IDLE: begin
          bitcnt <= '0;
          if (idle_pair) begin
            idle_before <= 1'b1;
          end
          if (locked && crs_hit) begin
            lstate <= frp_pkg::LS_CARRIER;
          end
        end
        frp_pkg::LS_CARRIER: begin
          bitcnt <= bitcnt + 4'h1;
          if (abort) begin
            lstate <= frp_pkg::LS_IDLE;
          end else if (jk_hit && idle_before) begin
            // Both preamble nibbles leave one symbol apart: one now, one held
            lstate <= frp_pkg::LS_DATA;
            emit_v <= 1'b1;
            emit_w <= pre_word;
            held <= pre_word;
            bitcnt <= '0;
            prev_t <= 1'b0;
          end else if (bitcnt == 4'(frp_pkg::WIN_BITS - 1)) begin
            lstate <= frp_pkg::LS_BAD;
            bitcnt <= '0;
          end
        end
        frp_pkg::LS_DATA: begin
          bitcnt <= bit_next;
          if (abort) begin
            emit_v <= 1'b1;
            emit_w <= frp_pkg::WORD_END;
            lstate <= frp_pkg::LS_IDLE;
            idle_before <= 1'b0;
          end else if (tick) begin
            emit_v <= 1'b1;
            if (prev_t && sym == frp_pkg::SYM_R) begin
              emit_w <= frp_pkg::WORD_END;
              lstate <= frp_pkg::LS_IDLE;
              idle_before <= 1'b0;
            end else if (prev_t) begin
              // A lone T is not a valid data code
              emit_w <= err_word;
              held <= sym_word;
              prev_t <= 1'b0;
            end else begin
              emit_w <= held;
              held <= sym_word;
              prev_t <= (sym == frp_pkg::SYM_T);
            end
          end
        end
        frp_pkg::LS_BAD: begin
          bitcnt <= bit_next;
          if (abort || idle_pair) begin
            emit_v <= 1'b1;
            emit_w <= frp_pkg::WORD_END;
            lstate <= frp_pkg::LS_IDLE;
            idle_before <= idle_pair;
          end else if (tick) begin
            emit_v <= 1'b1;
            emit_w <= bad_word;
          end
        end
        default: begin
          lstate <= frp_pkg::LS_IDLE;
        end
      endcase
    end
  end

  // Toggle request toward the system domain; the word holds until the next emit.
  // Limitation: an abort may emit one link clock after a symbol, and the copy takes
  // up to three system clocks, so the link clock must be slower than that
  logic [6:0] link_word;
  logic req_tog;
  logic ack_tog;

  always_ff @(posedge clk_link) begin
    if (!rst_l_b) begin
      link_word <= '0;
      req_tog <= 1'b0;
    end else if (ce_l && emit_v) begin
      link_word <= emit_w;
      req_tog <= ~req_tog;
    end
  end

  // ---------------- System clock domain ----------------
  logic req_m;
  logic req_s;
  logic buf_in_ready;
  logic buf_out_valid;
  logic [6:0] buf_out_data;
  logic [2:0] div;

  wire word_pending = (req_s != ack_tog);
  wire take = ce && word_pending && buf_in_ready;
  wire mii_edge = (div == frp_pkg::MII_CHANGE);
  wire pop = mii_edge && buf_out_valid;
  wire [2:0] next_div = (div == frp_pkg::MII_DIV_LAST) ? 3'h0 : div + 3'h1;

  always_ff @(posedge clk_sys) begin
    req_m <= req_tog;
    req_s <= req_m;
    if (!rst_b) begin
      ack_tog <= 1'b0;
    end else if (take) begin
      ack_tog <= ~ack_tog;
    end
  end

  // A full buffer only delays the copy; the MII side drains one word per five system clocks, as fast as words arrive from a 125 MHz link
  frp_buf2 #(
    .W(frp_pkg::WORD_W),
    .DEPTH(2)
  ) u_buf (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .ce(ce),
    .in_valid(word_pending),
    .in_ready(buf_in_ready),
    .in_data(link_word),
    .out_valid(buf_out_valid),
    .out_ready(mii_edge),
    .out_data(buf_out_data)
  );

  // Outputs change while rx_clk is low; an empty buffer holds the last values, so
  // a link slower than the MII rate stretches nibbles instead of dropping rx_dv
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      div <= '0;
      rx_clk <= 1'b0;
      rxd <= '0;
      rx_dv <= 1'b0;
      rx_er <= 1'b0;
      crs <= 1'b0;
    end else if (ce) begin
      div <= next_div;
      rx_clk <= (next_div < frp_pkg::MII_HIGH_END);
      if (pop) begin
        rxd <= buf_out_data[3:0];
        rx_dv <= buf_out_data[frp_pkg::W_DV];
        rx_er <= buf_out_data[frp_pkg::W_ER];
        crs <= buf_out_data[frp_pkg::W_CRS];
      end
    end
  end

  // ---------------- Checks ----------------
  property p_lock_run;
    @(posedge clk_link) disable iff (!rst_l_b)
    $rose(locked) |-> $past(match_cnt) == frp_pkg::RUN_W'(frp_pkg::LOCK_BITS - 1);
  endproperty
  a_lock_run: assert property (p_lock_run) else $error("lock without a full idle run");

  property p_hold_start;
    @(posedge clk_link) disable iff (!rst_l_b)
    $rose(locked) |-> hold_cnt == frp_pkg::frp_hold_t'(HOLD_CYCLES);
  endproperty
  a_hold_start: assert property (p_hold_start) else $error("hold timer not started");

  property p_hold_reload;
    @(posedge clk_link) disable iff (!rst_l_b)
    ce_l && reload |=> locked && hold_cnt == frp_pkg::frp_hold_t'(HOLD_CYCLES);
  endproperty
  a_hold_reload: assert property (p_hold_reload) else $error("hold timer not reloaded");

  property p_hold_expire;
    @(posedge clk_link) disable iff (!rst_l_b)
    ce_l && expire |=> !locked && match_cnt == '0;
  endproperty
  a_hold_expire: assert property (p_hold_expire) else $error("lock kept after expiry");

  property p_jk_start;
    @(posedge clk_link) disable iff (!rst_l_b)
    ce_l && lstate == frp_pkg::LS_CARRIER && jk_hit && idle_before && !abort
    |=> lstate == frp_pkg::LS_DATA && emit_v && emit_w == pre_word;
  endproperty
  a_jk_start: assert property (p_jk_start) else $error("start pair not framed");

  property p_bad_ssd;
    @(posedge clk_link) disable iff (!rst_l_b)
    ce_l && lstate == frp_pkg::LS_BAD && tick && !abort && !idle_pair
    |=> emit_v && emit_w == bad_word;
  endproperty
  a_bad_ssd: assert property (p_bad_ssd) else $error("bad start not flagged");

  property p_dv_follow;
    @(posedge clk_sys) disable iff (!rst_b)
    ce && pop |=> rx_dv == $past(buf_out_data[frp_pkg::W_DV])
                  && rxd == $past(buf_out_data[3:0]);
  endproperty
  a_dv_follow: assert property (p_dv_follow) else $error("rx_dv or rxd not from word");

  property p_er_in_packet;
    @(posedge clk_sys) disable iff (!rst_b)
    ce && pop && buf_out_data[frp_pkg::W_DV] && buf_out_data[frp_pkg::W_ER]
    |=> rx_dv && rx_er;
  endproperty
  a_er_in_packet: assert property (p_er_in_packet) else $error("rx_er missed");

  property p_mii_sync;
    @(posedge clk_sys) disable iff (!rst_b)
    $changed(rx_dv) || $changed(rxd) |-> !rx_clk && $past(rx_clk, 2);
  endproperty
  a_mii_sync: assert property (p_mii_sync) else $error("rx_dv changed off the rx_clk edge");

endmodule

// file: testbench/frp_line_tx.sv
/*
  Far-end transmitter model: 5B symbols sent MSB first, scrambled and NRZI coded.
  Assumes a free-running clk_link; sends idle (all ones) whenever its queue is empty.
*/
module frp_line_tx (
  input wire logic clk_link,
  output logic line_bit
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] q[$];
  logic [4:0] sym = 5'h1F;
  logic [2:0] cnt = 3'h0;
  // Arbitrary nonzero start state; the receiver must find it by itself
  logic [10:0] lfsr = 11'h5A5;
  wire logic key = lfsr[10] ^ lfsr[8];
  initial line_bit = 1'b0;
  function automatic int pending();
    return q.size() + ((cnt != 3'h0) ? 1 : 0);
  endfunction
  task automatic push(input logic [4:0] s);
    q.push_back(s);
  endtask
  always @(posedge clk_link) begin
    if (cnt == 3'h0) begin
      sym = (q.size() != 0) ? q.pop_front() : 5'h1F;
      cnt = 3'h5;
    end
    // A one toggles the line
    line_bit <= line_bit ^ (sym[4] ^ key);
    sym = {sym[3:0], 1'b0};
    cnt = cnt - 3'h1;
    lfsr <= {lfsr[9:0], key};
  end
endmodule

// file: testbench/frp_rx_pcs_test.sv
/*
  Self-checking bench for the receive PCS: packets, bad codes, false carrier, aborts, hold expiry.
  Assumes the far-end transmitter model and a short hold count for simulation.
*/
module frp_rx_pcs_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HOLD = 200;
  localparam logic [4:0] ENC [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
    5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
  logic clk_sys = 1'b0;
  logic clk_link = 1'b0;
  logic rst_b;
  logic ce;
  logic sig_det;
  logic link_ok;
  logic line_bit;
  logic rx_clk;
  logic rx_dv;
  logic rx_er;
  logic crs;
  logic [3:0] rxd;
  logic [3:0] rxd_q = 4'h0;
  logic rx_clk_q = 1'b0;
  logic rx_clk_qq = 1'b0;
  logic word_q = 1'b0;
  logic [3:0] got[$];
  logic dv_no_crs = 1'b0;
  logic sync_bad = 1'b0;
  int er_cnt = 0;
  int fc_cnt = 0;
  int miscompares = 0;
  int tests_run = 0;

  always #4 clk_sys = ~clk_sys;
  always #15 clk_link = ~clk_link;

  frp_rx_pcs #(.HOLD_CYCLES(HOLD)) i_frp_rx_pcs (.clk_sys(clk_sys), .rst_b(rst_b), .ce(ce),
    .clk_link(clk_link), .line_bit(line_bit), .sig_det(sig_det), .link_ok(link_ok),
    .rx_clk(rx_clk), .rxd(rxd), .rx_dv(rx_dv), .rx_er(rx_er), .crs(crs));
  frp_line_tx i_frp_line_tx (.clk_link(clk_link), .line_bit(line_bit));

  // MAC view: one record per word the MII side takes, read a cycle later once settled.
  // The link here is slower than the MII, so each nibble stands several rx_clk periods.
  always @(posedge clk_sys) begin
    if (word_q) begin
      if (rx_dv === 1'b1) got.push_back(rxd);
      if (rx_dv === 1'b1 && rx_er === 1'b1) er_cnt++;
      if (rx_dv !== 1'b1 && rx_er === 1'b1 && rxd === 4'hE && crs === 1'b1) fc_cnt++;
      if (rx_dv === 1'b1 && crs !== 1'b1) dv_no_crs = 1'b1;
    end
    word_q <= ce && i_frp_rx_pcs.pop;
  end
  // rxd may only move on the edge after rx_clk falls, one clock into its three-clock low phase
  always @(posedge clk_sys) begin
    if (rst_b === 1'b1 && rxd !== rxd_q && !(rx_clk_qq === 1'b1 && rx_clk_q === 1'b0))
      sync_bad = 1'b1;
    rxd_q <= rxd;
    rx_clk_q <= rx_clk;
    rx_clk_qq <= rx_clk_q;
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("Checks %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic drain(input int n);
    int k;
    k = 0;
    while (i_frp_line_tx.pending() != 0 && k < 5000) begin
      @(posedge clk_link);
      k++;
    end
    repeat (n) @(posedge clk_link);
  endtask

  task automatic wait_dv(input logic v, input int lim, input string what);
    int k;
    k = 0;
    while (rx_dv !== v && k < lim) begin
      @(posedge clk_sys);
      k++;
    end
    chk(what, 16'(v), 16'(rx_dv));
  endtask

  // Data nibbles count up modulo 16 so every code is decoded; bad < 0 means none
  task automatic send_frame(input int len, input int bad, input logic with_end);
    i_frp_line_tx.push(5'h18);
    i_frp_line_tx.push(5'h11);
    for (int i = 0; i < len; i++)
      i_frp_line_tx.push((i == bad) ? 5'h04 : ENC[i % 16]);
    if (with_end) begin
      i_frp_line_tx.push(5'h0D);
      i_frp_line_tx.push(5'h07);
    end
  endtask

  task automatic t_packet(input int bad);
    got.delete();
    er_cnt = 0;
    dv_no_crs = 1'b0;
    send_frame(16, bad, 1'b1);
    drain(80);
    chk("nibble count", 16'd18, 16'(got.size()));
    for (int i = 0; i < 2; i++)
      chk("preamble", 16'h5, (got.size() > i) ? 16'(got[i]) : 16'hFFFF);
    for (int i = 0; i < 16; i++)
      chk("data", (i == bad) ? 16'hE : 16'(i), (got.size() > i + 2) ? 16'(got[i + 2]) : 16'hFFFF);
    chk("error words", (bad >= 0) ? 16'd1 : 16'd0, 16'(er_cnt));
    chk("dv after end", 16'h0, 16'(rx_dv));
    chk("crs after end", 16'h0, 16'(crs));
    chk("dv outside crs", 16'h0, 16'(dv_no_crs));
  endtask

  task automatic t_false_carrier();
    got.delete();
    fc_cnt = 0;
    i_frp_line_tx.push(5'h0A);
    i_frp_line_tx.push(5'h0A);
    drain(80);
    chk("false carrier words", 16'h1, 16'(fc_cnt != 0));
    chk("no data on false carrier", 16'h0, 16'(got.size()));
    chk("crs after idles", 16'h0, 16'(crs));
    chk("er after idles", 16'h0, 16'(rx_er));
  endtask

  task automatic t_abort(input logic use_link);
    got.delete();
    send_frame(40, -1, 1'b1);
    wait_dv(1'b1, 2000, "dv rise");
    repeat (40) @(posedge clk_sys);
    if (use_link) link_ok <= 1'b0;
    else sig_det <= 1'b0;
    wait_dv(1'b0, 40, "dv drop on abort");
    chk("packet cut short", 16'h1, 16'(got.size() < 42));
    @(posedge clk_sys);
    link_ok <= 1'b1;
    sig_det <= 1'b1;
    drain(150);
  endtask

  task automatic t_hold_expiry();
    got.delete();
    send_frame(0, -1, 1'b0);
    for (int i = 0; i < 80; i++)
      i_frp_line_tx.push(ENC[5]);
    wait_dv(1'b1, 2000, "dv rise long frame");
    wait_dv(1'b0, 1200, "dv drop on hold expiry");
    chk("hold span", 16'h1, 16'(got.size() > 30 && got.size() < 70));
    drain(150);
  endtask

  // Clock enable low freezes the MII side; the link side loses step and has to relock
  task automatic t_freeze();
    logic [7:0] snap;
    int moved;
    int hi;
    moved = 0;
    hi = 0;
    @(posedge clk_sys);
    ce <= 1'b0;
    #1 snap = {rx_clk, rxd, rx_dv, rx_er, crs};
    repeat (20) begin
      @(posedge clk_sys);
      #1 if ({rx_clk, rxd, rx_dv, rx_er, crs} !== snap) moved++;
    end
    chk("outputs held while ce low", 16'h0, 16'(moved));
    @(posedge clk_sys);
    ce <= 1'b1;
    repeat (5) begin
      @(posedge clk_sys);
      #1 if (rx_clk === 1'b1) hi++;
    end
    chk("rx_clk high slots after ce", 16'h2, 16'(hi));
    drain(400);
  endtask

  initial begin
    #400us;
    miscompares++;
    $display("ERROR watchdog expected done seen hang");
    conclude();
  end

  initial begin
    rst_b <= 1'b0;
    ce <= 1'b1;
    sig_det <= 1'b1;
    link_ok <= 1'b1;
    // Longer than 15 cycles so reset spans four link clocks
    repeat (20) @(posedge clk_sys);
    rst_b <= 1'b1;
    // Values left by the last edge that still saw reset
    #1 chk("reset outputs", 16'h0, 16'({rx_clk, rxd, rx_dv, rx_er, crs}));
    drain(150);
    t_packet(-1);
    t_packet(7);
    t_false_carrier();
    t_packet(-1);
    t_abort(1'b0);
    t_abort(1'b1);
    t_hold_expiry();
    t_freeze();
    t_packet(-1);
    chk("rxd moves with rx_clk fall", 16'h0, 16'(sync_bad));
    conclude();
  end
endmodule
